// >>> psq_map.vh
// register offsets, field layouts, reset values and timing constants of the program sequencer
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH

// =====================================================
// apb register map (byte addresses)
`define PSQ_OFF_PCL 12'h000
`define PSQ_OFF_CTRL 12'h004
`define PSQ_OFF_STAT 12'h008
`define PSQ_OFF_ALU 12'h00C
`define PSQ_OFF_IR 12'h010

// =====================================================
// control register fields
`define PSQ_CTRL_RUN 0
`define PSQ_CTRL_IRQ_EN 1

// =====================================================
// widths, vectors and reset values
`define PSQ_PC_W 13
`define PSQ_PCH_W 5
`define PSQ_VEC_RESET 13'h0000
`define PSQ_VEC_IRQ 13'h0004
`define PSQ_STACK_DEPTH 8
`define PSQ_CTRL_RST 2'h0

// =====================================================
// instruction decode: opcode in bits 15:13
`define PSQ_OP_ALU 3'h0
`define PSQ_OP_JMP 3'h1
`define PSQ_OP_CALL 3'h2
`define PSQ_OP_RET 3'h3
`define PSQ_OP_RETURN_FROM_INTERRUPT 3'h4
`define PSQ_OP_SKZ 3'h5
`define PSQ_OP_WPCL 3'h6
`define PSQ_OP_EXT 3'h7

// alu function in bits 12:10
`define PSQ_FN_ADD 3'h0
`define PSQ_FN_SUB 3'h1
`define PSQ_FN_AND 3'h2
`define PSQ_FN_OR 3'h3
`define PSQ_FN_XOR 3'h4
`define PSQ_FN_RL 3'h5
`define PSQ_FN_INC 3'h6
`define PSQ_FN_DEC 3'h7

// =====================================================
// timing
`define PSQ_PHASES 4
`define PSQ_CLK_NS 10
`endif

// >>> psq_sequencer.v
// program sequencer core: phases, pc, return stack, alu status, apb slave
// Behaviour
// RULE1: system clock split into four phases; four phases form one instruction cycle
// RULE2: pc increments and next word is fetched at start of phase one
// RULE3: fetch overlaps execution; standard one cycle, extended two; an extended instruction here takes three, a held second cycle then a dummy
// RULE4: jumps and calls cost one extra instruction cycle
// RULE5: met skip discards prefetched word and runs a dummy cycle
// RULE6: pc is 13 bits, 5 high and 8 low; only low byte addressable
// RULE7: jumps, calls, interrupts and reset load a target into pc
// RULE8: pc low byte read/write; write jumps within current 256-word page
// RULE9: pc low byte write inserts a dummy cycle for prefetch
// RULE10: return stack holds 8 pc values; not software visible
// RULE11: call or interrupt acknowledge pushes pc; returns pop it
// RULE12: after reset stack pointer indicates top of stack
// RULE13: stack full holds interrupt pending until a return frees a level
// RULE14: call on full stack overflows, losing oldest saved pc
// RULE15: 8-bit alu does arithmetic, logic, rotate, inc, dec, branch decisions
// RULE16: status register updated with carry, borrow and zero after alu ops
// RULE17: program memory 8K x 16 addressed by pc; tables use a separate pointer
// RULE18: after reset execution starts at the reset vector
// RULE19: a return pop moves the pointer and clears the full condition
`include "psq_map.vh"

module psq_sequencer #(
  parameter PC_W = `PSQ_PC_W,
  parameter DEPTH = `PSQ_STACK_DEPTH
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] pmem_rdata,
  output reg [PC_W-1:0] pmem_addr,
  output reg pmem_rd,
  input wire irq_req,
  output reg irq_ack,
  output reg [1:0] cycle_phases,
  output reg stack_full
);

  // =====================================================
  // state
  reg [1:0] phase_r;
  // RULE6: 13-bit pc, only the low byte is software visible
  reg [PC_W-1:0] pc_r;
  reg [15:0] ir_r;
  reg ir_valid_r;
  reg dummy_r;
  reg ext_wait_r;
  // RULE10: eight pc slots, no register path to them
  reg [PC_W-1:0] stack_r [0:DEPTH-1];
  reg [3:0] sp_r;
  reg [7:0] acc_r;
  reg [3:0] status_r;
  reg [1:0] ctrl_r;
  reg irq_pend_r;
  reg apb_wpcl_r;
  reg [7:0] apb_pcl_r;
  integer i;

  wire run = ctrl_r[`PSQ_CTRL_RUN];
  wire full = (sp_r == DEPTH);
  wire [2:0] op = ir_r[15:13];
  wire [2:0] fn = ir_r[12:10];
  wire [7:0] imm = ir_r[7:0];
  localparam PH_FIRST = 2'd0;
  localparam PH_LAST = 2'd3;
  wire t1 = (phase_r == PH_FIRST);
  wire t4 = (phase_r == PH_LAST);
  // a phase-one edge fetches only when memory was strobed for it, which also
  // keeps the first edge after start from latching an unread bus
  wire fetch = run && t1 && pmem_rd;

  // =====================================================
  // alu: result in bits 7:0, carry in bit 8
  function [8:0] alu_f;
    input [2:0] f;
    input [7:0] a;
    input [7:0] b;
    begin
      case (f)
        `PSQ_FN_ADD: alu_f = {1'b0, a} + {1'b0, b};
        `PSQ_FN_SUB: alu_f = {1'b0, a} + {1'b0, ~b} + 9'h001;
        `PSQ_FN_AND: alu_f = {1'b0, a & b};
        `PSQ_FN_OR: alu_f = {1'b0, a | b};
        `PSQ_FN_XOR: alu_f = {1'b0, a ^ b};
        `PSQ_FN_RL: alu_f = {a[7], a[6:0], a[7]};
        `PSQ_FN_INC: alu_f = {1'b0, a} + 9'h001;
        `PSQ_FN_DEC: alu_f = {1'b0, a} + 9'h1FF;
        default: alu_f = 9'h000;
      endcase
    end
  endfunction

  // =====================================================
  // helpers shared by the sequencer and the register bus

  // two's complement overflow; logic and rotate never overflow
  function ovf_f;
    input [2:0] f;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      case (f)
        `PSQ_FN_ADD: ovf_f = (a[7] == b[7]) && (r[7] != a[7]);
        `PSQ_FN_SUB: ovf_f = (a[7] != b[7]) && (r[7] != a[7]);
        `PSQ_FN_INC: ovf_f = (a == 8'h7F);
        `PSQ_FN_DEC: ovf_f = (a == 8'h80);
        default: ovf_f = 1'b0;
      endcase
    end
  endfunction

  // page-local target: the high pc bits are kept, only the low byte moves
  function [PC_W-1:0] page_f;
    input [PC_W-1:0] pc;
    input [7:0] lo;
    begin
      page_f = {pc[PC_W-1:8], lo};
    end
  endfunction

  // slot of the newest entry; a full pointer of eight wraps to slot seven
  function [2:0] top_f;
    input [3:0] sp;
    begin
      top_f = sp[2:0] - 3'd1;
    end
  endfunction

  // next sequential address; wraps at the top of program memory
  function [PC_W-1:0] inc_f;
    input [PC_W-1:0] pc;
    begin
      inc_f = pc + 1'b1;
    end
  endfunction

  // mapped word offsets; everything else answers with an error
  function hit_f;
    input [11:0] a;
    begin
      case (a)
        `PSQ_OFF_PCL, `PSQ_OFF_CTRL, `PSQ_OFF_STAT, `PSQ_OFF_ALU, `PSQ_OFF_IR: hit_f = 1'b1;
        default: hit_f = 1'b0;
      endcase
    end
  endfunction

  wire [8:0] alu_res = alu_f(fn, acc_r, imm);

  // =====================================================
  // alu status flags
  // RULE16: flags from the alu result
  wire alu_carry = alu_res[8];
  wire alu_sign = alu_res[7];
  wire alu_zero = (alu_res[7:0] == 8'h00);
  wire alu_ovf = ovf_f(fn, acc_r, imm, alu_res[7:0]);
  // skip when the tested value is zero
  wire skip_met = (acc_r == 8'h00);
  wire take_irq = irq_pend_r && ctrl_r[`PSQ_CTRL_IRQ_EN] && !full;
  // taken only at a fetch edge that no pc write or second cycle claims
  wire irq_go = fetch && !apb_wpcl_r && !ext_wait_r && take_irq && !dummy_r;

  // =====================================================
  // apb slave: zero wait states
  wire apb_acc = psel && penable;
  wire apb_wr = apb_acc && pwrite;
  wire apb_map = hit_f(paddr);
  wire apb_setup = psel && !penable;
  // write strobes land in the access cycle, when pready is already high
  wire wr_ctrl = apb_wr && (paddr == `PSQ_OFF_CTRL);
  wire wr_pcl = apb_wr && (paddr == `PSQ_OFF_PCL);
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      // RULE8: low byte readable
      `PSQ_OFF_PCL: rd_nxt = {24'h000000, pc_r[7:0]};
      `PSQ_OFF_CTRL: rd_nxt = {30'h0, ctrl_r};
      `PSQ_OFF_STAT: rd_nxt = {26'h0, irq_pend_r, full, status_r};
      `PSQ_OFF_ALU: rd_nxt = {24'h000000, acc_r};
      `PSQ_OFF_IR: rd_nxt = {16'h0000, ir_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // answer one cycle after setup, so the access never waits
      pready <= apb_setup;
      pslverr <= apb_setup && !apb_map;
      prdata <= (apb_setup && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // =====================================================
  // control and pc low byte writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `PSQ_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // held until the next fetch edge consumes it, so a write made while the
  // core is halted still takes effect once it runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_wpcl_r <= 1'b0;
      apb_pcl_r <= 8'h00;
    end else if (wr_pcl) begin
      // RULE9: byte waits for the next fetch edge
      apb_wpcl_r <= 1'b1;
      apb_pcl_r <= pwdata[7:0];
    end else if (fetch) begin
      apb_wpcl_r <= 1'b0;
    end
  end

  // =====================================================
  // phase counter: halted, the core holds the phase it was in
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'd0;
      cycle_phases <= 2'd0;
    end else if (run) begin
      // RULE1: four phases per instruction cycle
      phase_r <= phase_r + 2'd1;
      cycle_phases <= phase_r + 2'd1;
    end
  end

  // =====================================================
  // interrupt pending: a new request in the taking cycle keeps it set
  // RULE13: flag recorded even while the stack is full
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_r <= 1'b0;
    end else if (irq_req) begin
      irq_pend_r <= 1'b1;
    end else if (irq_go) begin
      irq_pend_r <= 1'b0;
    end
  end

  // =====================================================
  // sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE18: reset vector
      pc_r <= `PSQ_VEC_RESET;
      pmem_addr <= `PSQ_VEC_RESET;
      pmem_rd <= 1'b0;
      ir_r <= 16'h0000;
      ir_valid_r <= 1'b0;
      dummy_r <= 1'b0;
      ext_wait_r <= 1'b0;
      // RULE12: empty stack on reset
      sp_r <= 4'd0;
      acc_r <= 8'h00;
      status_r <= 4'h0;
      irq_ack <= 1'b0;
      stack_full <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        stack_r[i] <= {PC_W{1'b0}};
    end else begin
      irq_ack <= 1'b0;
      stack_full <= full;
      pmem_rd <= run && t4;
      if (fetch) begin
        // RULE2: fetch and increment at start of phase one
        // RULE3: fetched word executes during next cycle
        // RULE17: program word addressed by the pc
        ir_r <= pmem_rdata;
        ir_valid_r <= 1'b1;
        pc_r <= inc_f(pc_r);
        pmem_addr <= inc_f(pc_r);
        dummy_r <= 1'b0;
        if (apb_wpcl_r) begin
          // RULE8: page-local jump, high bits kept
          // RULE9: dummy cycle while new target prefetched
          pc_r <= page_f(pc_r, apb_pcl_r);
          pmem_addr <= page_f(pc_r, apb_pcl_r);
          dummy_r <= 1'b1;
        end else if (ext_wait_r) begin
          // second cycle of an extended instruction
          ext_wait_r <= 1'b0;
          pc_r <= pc_r;
          pmem_addr <= pc_r;
          dummy_r <= 1'b1;
        end else if (take_irq && !dummy_r) begin
          // RULE11: interrupt acknowledge pushes pc
          // RULE7: load interrupt vector
          stack_r[sp_r[2:0]] <= pc_r - 1'b1;
          sp_r <= sp_r + 4'd1;
          irq_ack <= 1'b1;
          pc_r <= `PSQ_VEC_IRQ;
          pmem_addr <= `PSQ_VEC_IRQ;
          dummy_r <= 1'b1;
        end else if (ir_valid_r && !dummy_r) begin
          case (op)
            `PSQ_OP_ALU: begin
              // RULE15: 8-bit alu result to accumulator
              acc_r <= alu_res[7:0];
              // RULE16: status: zero, carry/borrow, sign, overflow
              status_r <= {alu_ovf, alu_sign, alu_carry, alu_zero};
            end
            `PSQ_OP_JMP: begin
              // RULE4: branch costs a dummy cycle
              // RULE7: target loaded, not incremented
              pc_r <= ir_r[PC_W-1:0];
              pmem_addr <= ir_r[PC_W-1:0];
              dummy_r <= 1'b1;
            end
            `PSQ_OP_CALL: begin
              // RULE11: push return address
              // RULE14: full stack overflows, oldest entry lost
              if (full) begin
                for (i = 0; i < DEPTH - 1; i = i + 1)
                  stack_r[i] <= stack_r[i+1];
                stack_r[DEPTH-1] <= pc_r;
              end else begin
                stack_r[sp_r[2:0]] <= pc_r;
                sp_r <= sp_r + 4'd1;
              end
              pc_r <= ir_r[PC_W-1:0];
              pmem_addr <= ir_r[PC_W-1:0];
              dummy_r <= 1'b1;
            end
            `PSQ_OP_RET, `PSQ_OP_RETURN_FROM_INTERRUPT: begin
              // RULE11: restore pc from stack
              // RULE19: pop frees a level, clearing full
              if (sp_r != 4'd0) begin
                pc_r <= stack_r[top_f(sp_r)];
                pmem_addr <= stack_r[top_f(sp_r)];
                sp_r <= sp_r - 4'd1;
              end
              dummy_r <= 1'b1;
            end
            `PSQ_OP_SKZ: begin
              // RULE5: discard prefetched word
              if (skip_met)
                dummy_r <= 1'b1;
            end
            `PSQ_OP_WPCL: begin
              // RULE8: software write of pc low byte
              // RULE9: dummy cycle for the prefetch
              pc_r <= page_f(pc_r, imm);
              pmem_addr <= page_f(pc_r, imm);
              dummy_r <= 1'b1;
            end
            `PSQ_OP_EXT: begin
              // RULE3: extended instructions hold for a second cycle
              ext_wait_r <= 1'b1;
              pc_r <= pc_r;
              pmem_addr <= pc_r;
            end
            default: acc_r <= acc_r;
          endcase
        end
      end
    end
  end

endmodule

// >>> psq_pmem_model.sv
// program memory partner: 8K x 16 words, junk on the bus outside fetches
module psq_pmem_model (
  input wire logic pclk,
  input wire logic pmem_rd,
  input wire logic [12:0] pmem_addr,
  output logic [15:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:8191];
  logic [15:0] junk = 16'hA5C3;
  // ==========
  // read port
  // toggling junk so a fetch taken off the pulse cannot match by luck
  always @(posedge pclk) junk <= ~junk;
  assign pmem_rdata = pmem_rd ? mem[pmem_addr] : junk;
endmodule

// >>> psq_sequencer_monitor.sv
// port checker for the program sequencer
module psq_sequencer_monitor #(
  parameter PC_W = 13,
  parameter DEPTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [PC_W-1:0] pmem_addr,
  input wire pmem_rd,
  input wire irq_ack,
  input wire [1:0] cycle_phases,
  input wire stack_full
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // core timing
  property p_step;
    $changed(cycle_phases) |-> cycle_phases == $past(cycle_phases) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("phase skipped");
  property p_fetch;
    pmem_rd |-> cycle_phases == 2'h0 ##1 (cycle_phases == 2'h1 && !pmem_rd);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch off phase");
  property p_pc;
    $changed(pmem_addr) |-> cycle_phases == 2'h1;
  endproperty
  a_pc: assert property (p_pc) else $error("pc moved mid cycle");
  property p_ack;
    irq_ack |-> !$past(stack_full) ##1 !irq_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack on full stack");
  property p_vec;
    $rose(irq_ack) |-> ##[0:8] pmem_addr == 'h4;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector load");
  // ==========
  // register bus
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("late pready");
  property p_rdy2;
    pready |-> psel && penable && !$past(penable);
  endproperty
  a_rdy2: assert property (p_rdy2) else $error("stray pready");
  property p_err;
    psel && !penable && paddr[1:0] == 2'h0 |=> pslverr == ($past(paddr) > 12'h010);
  endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  c_irq: cover property (irq_ack);
  c_full: cover property (stack_full);
  c_err: cover property (pslverr);
endmodule
bind psq_sequencer psq_sequencer_monitor #(.PC_W(PC_W), .DEPTH(DEPTH)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
  .irq_ack(irq_ack), .cycle_phases(cycle_phases), .stack_full(stack_full));

// >>> program_sequencer_tb.sv
// self-checking bench for the program sequencer
`include "psq_map.vh"
module program_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic irq_req = 1'h0, pready, pslverr, pmem_rd, irq_ack, stack_full;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] pmem_rdata;
  logic [12:0] pmem_addr;
  logic [1:0] cycle_phases;
  logic [32:0] exp_q[$];
  logic [7:0] r;
  bit seen [0:8191];
  int mismatches = 0, tests_run = 0, acks = 0, cyc = 0;
  psq_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_rdata(pmem_rdata), .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .irq_req(irq_req), .irq_ack(irq_ack),
    .cycle_phases(cycle_phases), .stack_full(stack_full));
  psq_pmem_model PM (.pclk(pclk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata));
  initial forever #5 pclk = ~pclk;
  // ==========
  // helpers
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic fetched(input int a);
    for (int k = 0; k < 4000 && !seen[a]; k++) @(posedge pclk);
    chk("fetch", 33'(seen[a]), 33'h1);
  endtask
  task automatic irq_pulse;
    irq_req <= 1'h1;
    @(posedge pclk);
    irq_req <= 1'h0;
  endtask
  // ==========
  // watcher: fetch log, acks, read results, hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (irq_ack === 1'h1) acks <= acks + 1;
    if (pmem_rd === 1'h1) seen[pmem_addr] <= 1'b1;
    if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0)
      chk("read", {pslverr, prdata}, exp_q.pop_front());
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========
  // program and sequence; unset words are jump-to-self traps
  initial begin
    r = 8'($urandom(32'h9E00)) | 8'h01;
    for (int i = 0; i < 8192; i++) PM.mem[i] = {`PSQ_OP_JMP, 13'(i)};
    PM.mem[0] = {`PSQ_OP_ALU, 5'h00, r};
    PM.mem[1] = {`PSQ_OP_JMP, 13'h0008};
    PM.mem[4] = {`PSQ_OP_ALU, 13'h0001};
    PM.mem[5] = {`PSQ_OP_RETURN_FROM_INTERRUPT, 13'h0000};
    PM.mem[8] = {`PSQ_OP_ALU, 5'h10, r};
    PM.mem[9] = {`PSQ_OP_SKZ, 13'h0000};
    PM.mem[11] = {`PSQ_OP_CALL, 13'h0100};
    PM.mem[12] = {`PSQ_OP_ALU, 13'h0080};
    PM.mem['h100] = {`PSQ_OP_WPCL, 13'h0020};
    PM.mem['h120] = {`PSQ_OP_RET, 13'h0000};
    PM.mem['h30] = {`PSQ_OP_ALU, 13'h0001};
    for (int i = 0; i < 9; i++) begin
      PM.mem['h40 + 16 * i] = {`PSQ_OP_CALL, 13'('h50 + 16 * i)};
      PM.mem['h41 + 16 * i] = {`PSQ_OP_RET, 13'h0000};
    end
    PM.mem['hD0] = {`PSQ_OP_RET, 13'h0000};
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("full", 33'(stack_full), 33'h0);
    rd(`PSQ_OFF_PCL, 33'h0);
    rd(`PSQ_OFF_STAT, 33'h0);
    rd(12'h014, {1'h1, 32'h0});
    xfer(1'h1, `PSQ_OFF_CTRL, 32'h1);
    fetched('hE);
    rd(`PSQ_OFF_ALU, 33'h80);
    rd(`PSQ_OFF_STAT, 33'h4);
    xfer(1'h1, `PSQ_OFF_PCL, 32'h30);
    fetched('h32);
    rd(`PSQ_OFF_ALU, 33'h81);
    xfer(1'h1, `PSQ_OFF_CTRL, 32'h3);
    irq_pulse();
    fetched(6);
    rd(`PSQ_OFF_ALU, 33'h82);
    chk("acks", 33'(acks), 33'h1);
    xfer(1'h1, `PSQ_OFF_PCL, 32'h40);
    fetched('hC0);
    repeat (4) @(posedge pclk);
    chk("full", 33'(stack_full), 33'h1);
    irq_pulse();
    fetched('h52);
    chk("lost", 33'(seen['h42]), 33'h0);
    chk("acks", 33'(acks), 33'h2);
    tally_and_finish();
  end
endmodule
